/* File: rtl/sirq_pkg.sv */
// sirq_pkg: register map, field positions, reset values and carrier types
// assumes a 16-bit register port with a small word index, single clock domain
package sirq_pkg;
	localparam logic [3:0]  ADDR_STATUS      = 4'h0;
	localparam logic [3:0]  ADDR_MASK        = 4'h1;
	localparam logic [3:0]  ADDR_PIN_CFG     = 4'h2;
	localparam logic [3:0]  ADDR_THRESH      = 4'h6;
	localparam logic [3:0]  ADDR_PIN_ALT     = 4'hB;
	localparam int          BIT_FLUSH        = 15;
	localparam int          BIT_RSVD7        = 7;
	localparam int          BIT_SLOT_B       = 6;
	localparam int          BIT_SLOT_A       = 5;
	localparam int          BIT_THR_BLOCK    = 8;
	localparam int          BIT_P1_DRV       = 9;
	localparam int          BIT_P1_POL       = 8;
	localparam int          BIT_P0_ENA       = 2;
	localparam int          BIT_P0_DRV       = 1;
	localparam int          BIT_P0_POL       = 0;
	localparam int          THR_LSB          = 8;
	localparam int          ALT_LSB          = 8;
	localparam logic [4:0]  RSVD_LOW_ALL     = 5'h1F;
	localparam logic [15:0] MASK_RESET       = 16'h01FF;
	localparam logic [15:0] PIN_CFG_RESET    = 16'h0000;
	localparam logic [5:0]  THRESH_RESET     = 6'h00;
	localparam logic [4:0]  ALT_RESET        = 5'h00;
	localparam logic [4:0]  ALT_IRQ          = 5'h01;
	localparam int          BUF_BYTES        = 128;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} sirq_req_t;

	typedef struct packed {
		logic valid;
		logic slot_a;
		logic slot_b;
		logic pop;
		logic [15:0] data;
	} sirq_smp_t;

	typedef struct packed {
		logic o;
		logic oe_n;
	} sirq_pin_t;
endpackage : sirq_pkg

/* File: rtl/sirq_pin_drv.sv */
// sirq_pin_drv: turns an internal interrupt level into pin level and enable
// assumes the pad resolves the wire; enable is active low
`timescale 1ns/1ps
module sirq_pin_drv
	import sirq_pkg::*;
(
	input  wire logic       irq_in,
	input  wire logic       enable_in,
	input  wire logic       open_drain_in,
	input  wire logic       active_low_in,
	output sirq_pkg::sirq_pin_t pin_out
);
	wire logic level_w = irq_in ^ active_low_in;
	wire logic drive_w = enable_in & (~open_drain_in | irq_in);
	assign pin_out.o    = level_w;
	assign pin_out.oe_n = ~drive_w;
endmodule : sirq_pin_drv

/* File: rtl/sirq_ctrl.sv */
// sirq_ctrl: interrupt status, masks, sample buffer and two interrupt pins
// assumes a synchronous 16-bit register port and a sample source that honours full
//
// Summary of operation
// - status upper byte reports bytes currently held in the sample buffer
// - writing one to status bit 15 empties the sample buffer
// - reserved status bit 7 clears when written with one
// - reserved status bits 4:0 clear when all five are written with ones
// - slot flags at bits 6 and 5 set on event, clear on one
// - writing zero to a slot flag leaves it unchanged
// - each slot interrupt raised on its sample if its mask permits
// - threshold block bit 8 enables when zero, blocks when one, resets one
// - slot block bits 6 and 5 disable when one, reset to one
// - pin one drive bit 9: zero always driven, one open drain
// - pin one polarity bit 8: zero active high, one active low
// - pin zero enable bit 2 low floats pin, status keeps working
// - threshold interrupt holds while stored words exceed threshold
// - pin zero polarity bit 0: zero active high, one active low
// - pin one carries the interrupt when its function select is one
`timescale 1ns/1ps
module sirq_ctrl
	import sirq_pkg::*;
(
	input  wire logic                clk_sys_in,
	input  wire logic                arst_n_in,
	input  wire logic                ce_in,
	input  wire sirq_pkg::sirq_req_t req_in,
	input  wire sirq_pkg::sirq_smp_t smp_in,
	output logic [15:0]              rdata_out,
	output logic [15:0]              pop_data_out,
	output logic                     buf_full_out,
	output sirq_pkg::sirq_pin_t      pin_zero_out,
	output sirq_pkg::sirq_pin_t      pin_one_out
);
	import sirq_pkg::*;

	localparam int AW = $clog2(BUF_BYTES / 2);

	logic [15:0]   mem [BUF_BYTES / 2];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   words_r;
	logic          flag_a_r;
	logic          flag_b_r;
	logic          rsvd7_r;
	logic [4:0]    rsvd_lo_r;
	logic [15:0]   mask_r;
	logic [15:0]   pcfg_r;
	logic [5:0]    thr_r;
	logic [4:0]    alt_r;
	logic          irq_r;
	sirq_pin_t     p0_w;
	sirq_pin_t     p1_w;

	function automatic logic hit(input sirq_req_t r, input logic [3:0] a);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	wire logic       wr_stat_w = hit(req_in, ADDR_STATUS);
	wire logic       flush_w   = wr_stat_w & req_in.wdata[BIT_FLUSH];
	wire logic       full_w    = words_r == (AW + 1)'(BUF_BYTES / 2);
	wire logic       push_w    = smp_in.valid & ~full_w & ~flush_w;
	wire logic       pop_w     = smp_in.pop & (words_r != '0) & ~flush_w;
	wire logic [7:0] bytes_w   = 8'({words_r, 1'b0}); // one word holds two bytes
	wire logic       thr_hit_w = 7'(words_r) > {1'b0, thr_r};
	wire logic       src_a_w   = flag_a_r & ~mask_r[BIT_SLOT_A];
	wire logic       src_b_w   = flag_b_r & ~mask_r[BIT_SLOT_B];
	wire logic       src_t_w   = thr_hit_w & ~mask_r[BIT_THR_BLOCK];
	wire logic       irq_nxt   = src_a_w | src_b_w | src_t_w;
	wire logic       p1_irq_w  = (alt_r == ALT_IRQ) & irq_r;
	// set wins over a simultaneous clear
	wire logic       a_nxt     = smp_in.slot_a | (flag_a_r & ~(wr_stat_w & req_in.wdata[BIT_SLOT_A]));
	wire logic       b_nxt     = smp_in.slot_b | (flag_b_r & ~(wr_stat_w & req_in.wdata[BIT_SLOT_B]));
	wire logic [15:0] stat_w   = {bytes_w, rsvd7_r, flag_b_r, flag_a_r, rsvd_lo_r};

	logic [15:0] rd_nxt;
	always_comb begin
		case (req_in.addr)
			ADDR_STATUS:  rd_nxt = stat_w;
			ADDR_MASK:    rd_nxt = mask_r;
			ADDR_PIN_CFG: rd_nxt = pcfg_r;
			ADDR_THRESH:  rd_nxt = 16'({thr_r, 8'h00});
			ADDR_PIN_ALT: rd_nxt = 16'({alt_r, 8'h00});
			default:      rd_nxt = 16'h0000;
		endcase
	end

	// pin 0 always carries the interrupt; pin 1 only in interrupt function
	sirq_pin_drv u_drv0 (
		.irq_in        (irq_r),
		.enable_in     (pcfg_r[BIT_P0_ENA]),
		.open_drain_in (pcfg_r[BIT_P0_DRV]),
		.active_low_in (pcfg_r[BIT_P0_POL]),
		.pin_out       (p0_w)
	);
	sirq_pin_drv u_drv1 (
		.irq_in        (p1_irq_w),
		.enable_in     (1'b1),
		.open_drain_in (pcfg_r[BIT_P1_DRV]),
		.active_low_in (pcfg_r[BIT_P1_POL]),
		.pin_out       (p1_w)
	);

	always_ff @(posedge clk_sys_in) begin
		if (ce_in && push_w) begin
			mem[wp_r] <= smp_in.data;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wp_r    <= '0;
			rp_r    <= '0;
			words_r <= '0;
		end else if (ce_in) begin
			if (flush_w) begin
				wp_r    <= '0;
				rp_r    <= '0;
				words_r <= '0;
			end else begin
				wp_r    <= wp_r + AW'(push_w);
				rp_r    <= rp_r + AW'(pop_w);
				words_r <= words_r + (AW + 1)'(push_w) - (AW + 1)'(pop_w);
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flag_a_r  <= 1'b0;
			flag_b_r  <= 1'b0;
			rsvd7_r   <= 1'b0;
			rsvd_lo_r <= 5'h00;
		end else if (ce_in) begin
			flag_a_r <= a_nxt;
			flag_b_r <= b_nxt;
			if (wr_stat_w && req_in.wdata[BIT_RSVD7]) begin
				rsvd7_r <= 1'b0;
			end
			if (wr_stat_w && req_in.wdata[4:0] == RSVD_LOW_ALL) begin
				rsvd_lo_r <= 5'h00;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mask_r <= MASK_RESET;
			pcfg_r <= PIN_CFG_RESET;
			thr_r  <= THRESH_RESET;
			alt_r  <= ALT_RESET;
		end else if (ce_in) begin
			if (hit(req_in, ADDR_MASK)) begin
				mask_r <= req_in.wdata;
			end
			if (hit(req_in, ADDR_PIN_CFG)) begin
				pcfg_r <= req_in.wdata;
			end
			if (hit(req_in, ADDR_THRESH)) begin
				thr_r <= req_in.wdata[THR_LSB +: 6];
			end
			if (hit(req_in, ADDR_PIN_ALT)) begin
				alt_r <= req_in.wdata[ALT_LSB +: 5];
			end
		end
	end

	// outputs registered; pin level lags the interrupt by one cycle
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_r        <= 1'b0;
			rdata_out    <= 16'h0000;
			pop_data_out <= 16'h0000;
			buf_full_out <= 1'b0;
			pin_zero_out <= '{o: 1'b0, oe_n: 1'b1};
			pin_one_out  <= '{o: 1'b0, oe_n: 1'b0};
		end else if (ce_in) begin
			irq_r        <= irq_nxt;
			rdata_out    <= rd_nxt;
			pop_data_out <= mem[rp_r];
			buf_full_out <= full_w;
			pin_zero_out <= p0_w;
			pin_one_out  <= p1_w;
		end
	end
endmodule : sirq_ctrl

/* File: verif/sirq_ctrl_properties.sv */
// sirq_chk: port checks for sirq_ctrl
// assumes ce_in mostly high; the mirrors follow only writes taken while it is high
`timescale 1ns/1ps
module sirq_chk
	import sirq_pkg::*;
(
	input wire logic                clk_sys_in,
	input wire logic                arst_n_in,
	input wire logic                ce_in,
	input wire sirq_pkg::sirq_req_t req_in,
	input wire sirq_pkg::sirq_smp_t smp_in,
	input wire logic [15:0]         rdata_out,
	input wire logic                buf_full_out,
	input wire sirq_pkg::sirq_pin_t pin_zero_out,
	input wire sirq_pkg::sirq_pin_t pin_one_out
);
	logic [15:0] msk_r;
	logic [15:0] cfg_r;
	wire w = ce_in && req_in.wr;
	wire rs = ce_in && req_in.addr == ADDR_STATUS;
	// mirrors let pin checks know the programmed mode
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			msk_r <= MASK_RESET;
			cfg_r <= PIN_CFG_RESET;
		end else begin
			if (w && req_in.addr == ADDR_MASK) msk_r <= req_in.wdata;
			if (w && req_in.addr == ADDR_PIN_CFG) cfg_r <= req_in.wdata;
		end
	end
	wire q = msk_r[8] && msk_r[6] && msk_r[5];
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	chk_rsvd_reads_zero: assert property (rs |=> rdata_out[7] == 1'b0 && rdata_out[4:0] == 5'h00)
		else $error("reserved bit set");
	chk_unmapped_zero: assert property (ce_in && req_in.addr == 4'h3 |=> rdata_out == 16'h0000)
		else $error("unmapped read");
	chk_flag_sets: assert property (ce_in && smp_in.slot_a ##1 rs |=> rdata_out[BIT_SLOT_A])
		else $error("flag not set");
	// a slot event on the same edge wins over the clear, so it is left out
	chk_flag_clears: assert property (w && rs && req_in.wdata[BIT_SLOT_B] && !smp_in.slot_b
		##1 rs |=> !rdata_out[6])
		else $error("flag not cleared");
	// the full flag lags one edge, so a pop or flush on that edge is left out
	chk_full_count: assert property (buf_full_out && rs && $past(ce_in) && !$past(smp_in.pop)
		&& !$past(w && req_in.addr == ADDR_STATUS && req_in.wdata[BIT_FLUSH])
		|=> rdata_out[15:8] == 8'h80)
		else $error("count wrong");
	chk_pin_floats: assert property (!cfg_r[BIT_P0_ENA] [*3] |-> pin_zero_out.oe_n)
		else $error("pin zero driven");
	chk_idle_level: assert property ((q && $stable(cfg_r)) [*4] |-> pin_one_out.oe_n == cfg_r[9]
		&& (cfg_r[9] || pin_one_out.o == cfg_r[8]))
		else $error("pin one idle");
	// a mask or pin write inside the three-cycle latency would change the answer
	chk_slot_raise: assert property (ce_in && smp_in.slot_a && !msk_r[5] && cfg_r[2:0] == 3'h4
		&& !w ##1 (ce_in && !w) [*2] |=> pin_zero_out.o && !pin_zero_out.oe_n)
		else $error("no irq");
	cover property (buf_full_out);
	cover property (smp_in.slot_a && !msk_r[5]);
	cover property (!pin_one_out.oe_n && cfg_r[9]);
endmodule : sirq_chk
bind sirq_ctrl sirq_chk i_sirq_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
	.ce_in(ce_in), .req_in(req_in), .smp_in(smp_in), .rdata_out(rdata_out),
	.buf_full_out(buf_full_out), .pin_zero_out(pin_zero_out), .pin_one_out(pin_one_out));

/* File: verif/sirq_host_model.sv */
// sirq_host_model: host view of both interrupt lines
// assumes pull-ups on both lines
`timescale 1ns/1ps
module sirq_host_model
	import sirq_pkg::*;
(
	input  wire sirq_pkg::sirq_pin_t pin_zero_in,
	input  wire sirq_pkg::sirq_pin_t pin_one_in,
	output logic                     line_zero_out,
	output logic                     line_one_out
);
	// a released line reads the pull-up, never the last driven level
	assign line_zero_out = pin_zero_in.oe_n ? 1'b1 : pin_zero_in.o;
	assign line_one_out  = pin_one_in.oe_n ? 1'b1 : pin_one_in.o;
endmodule : sirq_host_model

/* File: verif/test_sensor_irq_status_and_pin_ctrl.sv */
// test_sensor_irq_status_and_pin_ctrl: register tests of sirq_ctrl
// assumes host model with pull-ups
`timescale 1ns/1ps
module test_sensor_irq_status_and_pin_ctrl;
	import sirq_pkg::*;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b0;
	sirq_req_t rq = '0;
	sirq_smp_t sm = '0;
	logic [15:0] rd_v, pd;
	logic full, l0, l1;
	sirq_pin_t p0, p1;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic ce = 1'b1;
	sirq_ctrl i_sirq_ctrl (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(ce),
		.req_in(rq), .smp_in(sm), .rdata_out(rd_v), .pop_data_out(pd),
		.buf_full_out(full), .pin_zero_out(p0), .pin_one_out(p1));
	sirq_host_model i_sirq_host_model (.pin_zero_in(p0), .pin_one_in(p1),
		.line_zero_out(l0), .line_one_out(l1));
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	task chk(input logic [15:0] v, input logic [15:0] e);
		cmp_count++;
		if (v !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, v, e);
			fail_count++;
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_in) rq <= {1'b1, 1'b0, a, d};
		@(posedge clk_sys_in) rq.wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_sys_in) rq <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge clk_sys_in) #1 chk(rd_v, e);
	endtask : rd
	task ev(input logic [3:0] k, input logic [15:0] d);
		@(posedge clk_sys_in) sm <= {k, d};
		@(posedge clk_sys_in) sm <= '0;
	endtask : ev
	task w4;
		repeat (4) @(posedge clk_sys_in);
		#1;
	endtask : w4
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		rd(ADDR_MASK, MASK_RESET);
		rd(4'h3, 16'h0000);
		chk(l0, 1'b1);
		wr(ADDR_PIN_CFG, 16'h0004);
		wr(ADDR_MASK, 16'h019F);
		for (int i = 0; i < 2; i++) begin
			// leaves the status address up, so the read after the slot A event is checked too
			rd(ADDR_STATUS, 16'h0000);
			ev(i == 0 ? 4'h4 : 4'h2, 16'h0000);
			w4;
			chk(l0, 1'b1);
			wr(ADDR_STATUS, 16'h009F);
			rd(ADDR_STATUS, 16'h0020 << i);
			wr(ADDR_STATUS, 16'h0020 << i);
			w4;
			chk(l0, 1'b0);
		end
		$display("slot flags done");
		wr(ADDR_PIN_CFG, 16'h0005);
		w4;
		chk(p0, 2'h2);
		ev(4'h4, 16'h0000);
		wr(ADDR_PIN_CFG, 16'h0301);
		wr(ADDR_PIN_ALT, 16'h0100);
		rd(ADDR_PIN_ALT, 16'h0100);
		rd(ADDR_PIN_CFG, 16'h0301);
		w4;
		chk(l0, 1'b1);
		chk(p1, 2'h0);
		rd(ADDR_STATUS, 16'h0020);
		wr(ADDR_STATUS, 16'h0020);
		w4;
		chk(p1.oe_n, 1'b1);
		chk(l1, 1'b1);
		$display("pins done");
		wr(ADDR_PIN_CFG, 16'h0004);
		wr(ADDR_THRESH, 16'h3F00);
		rd(ADDR_THRESH, 16'h3F00);
		// one push past full must be dropped
		for (int i = 0; i < 65; i++) ev(4'h8, 16'hA500 + 16'(i));
		w4;
		chk(full, 1'b1);
		rd(ADDR_STATUS, 16'h8000);
		chk(l0, 1'b0);
		wr(ADDR_MASK, 16'h00FF);
		w4;
		chk(l0, 1'b1);
		chk(pd, 16'hA500);
		ev(4'h1, 16'h0000);
		w4;
		chk(l0, 1'b0);
		chk(pd, 16'hA501);
		rd(ADDR_STATUS, 16'h7E00);
		wr(ADDR_PIN_CFG, 16'h0006);
		w4;
		chk(p0.oe_n, 1'b1);
		chk(l0, 1'b1);
		wr(ADDR_STATUS, 16'h8000);
		rd(ADDR_STATUS, 16'h0000);
		$display("buffer done");
		// an event while the clock enable is low must leave no trace
		@(posedge clk_sys_in) ce <= 1'b0;
		ev(4'h4, 16'h0000);
		@(posedge clk_sys_in) ce <= 1'b1;
		rd(ADDR_STATUS, 16'h0000);
		$display("clock enable done");
		print_verdict();
	end
endmodule : test_sensor_irq_status_and_pin_ctrl
